// [hw/axis_limit_pkg.sv]
// Shared constants, register map and carrier types of the axis limit block.
package axis_limit_pkg;
	localparam int CLOCK_MHZ = 100;
	localparam int SERVO_PERIOD_US = 1000;
	localparam int SERVO_TICK_CYCLES = SERVO_PERIOD_US * CLOCK_MHZ;

	localparam logic [5:0] REG_SOFT_LIMIT = 6'h00;
	localparam logic [5:0] REG_REPEAT_DIST = 6'h04;
	localparam logic [5:0] REG_FWD_LIMIT_SEL = 6'h08;
	localparam logic [5:0] REG_FORWARD_JOG_INPUT_SELECT_SEL = 6'h0C;
	localparam logic [5:0] REG_AXIS_TYPE = 6'h10;
	localparam logic [5:0] REG_STATE_WORD = 6'h14;
	localparam logic [5:0] REG_MOVE_CTRL = 6'h18;
	localparam logic [5:0] REG_SPEED = 6'h1C;
	localparam logic [5:0] REG_RAMP_STEP = 6'h20;
	localparam logic [5:0] REG_PSW_CMD = 6'h24;
	localparam logic [5:0] REG_TABLE_ADDR = 6'h28;
	localparam logic [5:0] REG_TABLE_DATA = 6'h2C;
	localparam logic [5:0] REG_PSW_STATUS = 6'h30;

	localparam int STATE_FWD_HW_LIMIT_BIT = 4;
	localparam int STATE_FWD_SOFT_LIMIT_BIT = 9;

	localparam logic [7:0] SEL_NONE = 8'hFF;
	localparam logic [7:0] SEL_MAX = 8'h1F;
	localparam logic [7:0] SEL_DRIVER_BASE = 8'h10;
	localparam logic [7:0] AXIS_TYPE_CODE_PSW_A = 8'h2B;
	localparam logic [7:0] AXIS_TYPE_CODE_PSW_B = 8'h2C;
	localparam logic [7:0] AXIS_TYPE_CODE_PSW_C = 8'h2D;

	localparam logic [31:0] SOFT_LIMIT_RESET = 32'h7FFF_FFFF;
	localparam logic [31:0] REPEAT_DIST_RESET = 32'h0010_0000;
	localparam logic [15:0] SPEED_RESET = 16'h0000;
	localparam logic [15:0] RAMP_RESET = 16'h0001;
	localparam logic [7:0] AXIS_TYPE_CODE_RESET = 8'h00;

	localparam int TABLE_DEPTH = 32;
	localparam int TABLE_AW = 5;
	localparam int FIFO_DEPTH = 32;
	localparam int FIFO_CW = 6;

	typedef enum logic [1:0] {
		PSW_DISABLE,
		PSW_ENABLE,
		PSW_CLEAR,
		PSW_UNUSED
	} psw_mode_t;

	typedef struct packed {
		logic [10:0] spare;
		logic [TABLE_AW-1:0] table_end;
		logic [2:0] spare_b;
		logic [TABLE_AW-1:0] table_start;
		logic [3:0] spare_c;
		logic opstate;
		logic direction;
		psw_mode_t mode;
	} psw_cmd_t;
endpackage

// [hw/compare_table.sv]
// Flip-flop table of compare positions, written and read by index.
module compare_table
	import axis_limit_pkg::*;
(
	input wire logic clock_i, // System clock.
	input wire logic resetn_i, // Asynchronous reset, active low.
	input wire logic wr_en_i, // Write strobe.
	input wire logic [TABLE_AW-1:0] wr_idx_i, // Write index.
	input wire logic [31:0] wr_data_i, // Write data.
	input wire logic [TABLE_AW-1:0] rd_idx_i, // Read index.
	output logic [31:0] rd_data_o // Entry at the read index.
);
	logic [31:0] mem_ff [TABLE_DEPTH];

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < TABLE_DEPTH; i++) begin
				mem_ff[i] <= 32'h0000_0000;
			end
		end else if (wr_en_i) begin
			mem_ff[wr_idx_i] <= wr_data_i;
		end
	end

	assign rd_data_o = mem_ff[rd_idx_i];
endmodule

// [hw/position_fifo.sv]
// First-in first-out queue of compare positions held in flip-flops.
module position_fifo
	import axis_limit_pkg::*;
(
	input wire logic clock_i, // System clock.
	input wire logic resetn_i, // Asynchronous reset, active low.
	input wire logic clear_i, // Empties the queue.
	input wire logic push_i, // Appends push_data_i when not full.
	input wire logic [31:0] push_data_i, // Position to append.
	input wire logic pop_i, // Drops the head when not empty.
	output logic [31:0] head_o, // Oldest position.
	output logic empty_o, // Queue is empty.
	output logic full_o, // Queue is full.
	output logic [FIFO_CW-1:0] count_o // Entries held.
);
	logic [31:0] mem_ff [FIFO_DEPTH];
	logic [TABLE_AW-1:0] rd_ff;
	logic [TABLE_AW-1:0] wr_ff;
	logic [FIFO_CW-1:0] count_ff;
	logic do_push;
	logic do_pop;

	assign empty_o = (count_ff == '0);
	assign full_o = (count_ff == FIFO_CW'(FIFO_DEPTH));
	assign count_o = count_ff;
	assign head_o = mem_ff[rd_ff];
	assign do_push = push_i && !full_o;
	assign do_pop = pop_i && !empty_o;

	always_ff @(posedge clock_i) begin
		if (do_push) begin
			mem_ff[wr_ff] <= push_data_i;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_ff <= '0;
			wr_ff <= '0;
			count_ff <= '0;
		end else if (clear_i) begin
			rd_ff <= '0;
			wr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (do_push) begin
				wr_ff <= wr_ff + 1'b1;
			end
			if (do_pop) begin
				rd_ff <= rd_ff + 1'b1;
			end
			count_ff <= count_ff + FIFO_CW'(do_push) - FIFO_CW'(do_pop);
		end
	end
endmodule

// [hw/axis_forward_limit.sv]
// Forward limits, forward jog and hardware position switch of one axis.
module axis_forward_limit
	import axis_limit_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = SERVO_TICK_CYCLES
) (
	input wire logic clock_i, // 100 MHz system clock.
	input wire logic resetn_i, // Asynchronous reset, active low.
	input wire logic [5:0] avs_address_i, // Avalon byte address.
	input wire logic avs_read_i, // Avalon read request.
	input wire logic avs_write_i, // Avalon write request.
	input wire logic [31:0] avs_writedata_i, // Avalon write data.
	input wire logic [3:0] avs_byteenable_i, // Avalon byte enables.
	output logic [31:0] avs_readdata_o, // Avalon read data.
	output logic avs_waitrequest_o, // Avalon wait request.
	input wire logic [31:0] measured_position_i, // Measured position.
	input wire logic [15:0] unit_inputs_n_i, // Shared unit inputs.
	input wire logic [15:0] driver_inputs_n_i, // This axis's driver inputs.
	output logic [15:0] speed_o, // Commanded forward speed.
	output logic digital_output_8_o // Position switch output.
);
	typedef enum {MV_IDLE, MV_RUN, MV_STOP} move_state_t;
	typedef enum {PS_IDLE, PS_LOAD} load_state_t;

	logic [31:0] soft_limit_ff, repeat_dist_ff, state_word_ff, readdata_ff;
	logic [7:0] fwd_limit_sel_ff, forward_jog_input_select_sel_ff, axis_type_ff;
	logic [15:0] target_speed_ff, ramp_step_ff, speed_ff;
	logic [TABLE_AW-1:0] table_addr_ff, load_idx_ff, load_end_ff;
	logic [31:0] tick_cnt_ff;
	logic resp_ff, tick, jog_move_ff, out8_ff;
	move_state_t move_ff;
	load_state_t load_ff;
	logic psw_enabled_ff, psw_dir_ff, psw_opstate_ff, psw_first_done_ff;
	logic req, wr_take, psw_axis_ok, table_wr, psw_match;
	logic [31:0] wdata, table_rd_data, fifo_head;
	psw_cmd_t cmd;
	logic soft_active, soft_reached, hw_limit, jog_active;
	logic fifo_clear, fifo_push, fifo_pop, fifo_empty, fifo_full;
	logic [FIFO_CW-1:0] fifo_count;

	// Returns whether the selected input is asserted; inputs pull low.
	function automatic logic input_asserted(input logic [7:0] sel,
			input logic [15:0] unit_n, input logic [15:0] drv_n);
		logic hit;
		hit = 1'b0;
		if (sel <= SEL_MAX) begin
			if (sel < SEL_DRIVER_BASE) begin
				hit = !unit_n[sel[3:0]];
			end else begin
				hit = !drv_n[sel[3:0]];
			end
		end
		return hit;
	endfunction

	// Only -1 or 0 to 31 is a legal selector value.
	function automatic logic sel_legal(input logic [31:0] v);
		return (v[7:0] == SEL_NONE && v[31:8] == 24'hFF_FFFF) ||
			(v <= 32'(SEL_MAX));
	endfunction

	// Writes to the soft limit and repeat distance honour byte enables lane by lane.
	function automatic logic [31:0] merge_bytes(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// The bus answers on the second edge of a request; any request
	// waits while the queue is being loaded.
	assign req = avs_read_i || avs_write_i;
	assign avs_waitrequest_o = req && !resp_ff;
	assign wr_take = avs_write_i && resp_ff;
	assign avs_readdata_o = readdata_ff;
	assign wdata = avs_writedata_i;
	assign cmd = psw_cmd_t'(avs_writedata_i);

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			resp_ff <= 1'b0;
		end else begin
			resp_ff <= req && !resp_ff && (load_ff == PS_IDLE);
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			readdata_ff <= 32'h0000_0000;
		end else if (req && !resp_ff) begin
			unique case (avs_address_i)
				REG_SOFT_LIMIT: readdata_ff <= soft_limit_ff;
				REG_REPEAT_DIST: readdata_ff <= repeat_dist_ff;
				REG_FWD_LIMIT_SEL: readdata_ff <= {{24{fwd_limit_sel_ff[7]}},
					fwd_limit_sel_ff};
				REG_FORWARD_JOG_INPUT_SELECT_SEL: readdata_ff <= {{24{forward_jog_input_select_sel_ff[7]}},
					forward_jog_input_select_sel_ff};
				REG_AXIS_TYPE: readdata_ff <= {24'h00_0000, axis_type_ff};
				REG_STATE_WORD: readdata_ff <= state_word_ff;
				REG_MOVE_CTRL: readdata_ff <= {30'h0000_0000,
					jog_move_ff, move_ff != MV_IDLE};
				REG_SPEED: readdata_ff <= {speed_ff, target_speed_ff};
				REG_RAMP_STEP: readdata_ff <= {16'h0000, ramp_step_ff};
				REG_TABLE_ADDR: readdata_ff <= {27'h000_0000, table_addr_ff};
				REG_TABLE_DATA: readdata_ff <= table_rd_data;
				REG_PSW_STATUS: readdata_ff <= {20'h0_0000, fifo_count,
					fifo_full, fifo_empty, psw_first_done_ff, out8_ff,
					psw_dir_ff, psw_enabled_ff};
				default: readdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	// Configuration registers.
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			soft_limit_ff <= SOFT_LIMIT_RESET;
			repeat_dist_ff <= REPEAT_DIST_RESET;
			axis_type_ff <= AXIS_TYPE_CODE_RESET;
			target_speed_ff <= SPEED_RESET;
			ramp_step_ff <= RAMP_RESET;
			table_addr_ff <= '0;
		end else if (wr_take) begin
			unique case (avs_address_i)
				REG_SOFT_LIMIT: soft_limit_ff <= merge_bytes(soft_limit_ff,
					wdata, avs_byteenable_i);
				REG_REPEAT_DIST: repeat_dist_ff <= merge_bytes(repeat_dist_ff,
					wdata, avs_byteenable_i);
				REG_AXIS_TYPE: axis_type_ff <= wdata[7:0];
				REG_SPEED: target_speed_ff <= wdata[15:0];
				REG_RAMP_STEP: ramp_step_ff <= wdata[15:0];
				REG_TABLE_ADDR: table_addr_ff <= wdata[TABLE_AW-1:0];
				default: ;
			endcase
		end
	end

	// Illegal selector values are dropped and the old value kept.
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fwd_limit_sel_ff <= SEL_NONE;
			forward_jog_input_select_sel_ff <= SEL_NONE;
		end else if (wr_take && sel_legal(wdata)) begin
			if (avs_address_i == REG_FWD_LIMIT_SEL) begin
				fwd_limit_sel_ff <= wdata[7:0];
			end
			if (avs_address_i == REG_FORWARD_JOG_INPUT_SELECT_SEL) begin
				forward_jog_input_select_sel_ff <= wdata[7:0];
			end
		end
	end

	// Servo update divider.
	assign tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tick_cnt_ff <= 32'h0000_0000;
		end else if (tick) begin
			tick_cnt_ff <= 32'h0000_0000;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
		end
	end

	assign soft_active = !($signed(soft_limit_ff) >
		$signed(repeat_dist_ff));
	assign soft_reached = soft_active &&
		($signed(measured_position_i) >= $signed(soft_limit_ff));
	assign hw_limit = input_asserted(fwd_limit_sel_ff, unit_inputs_n_i,
		driver_inputs_n_i);
	assign jog_active = input_asserted(forward_jog_input_select_sel_ff, unit_inputs_n_i,
		driver_inputs_n_i);

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_word_ff <= 32'h0000_0000;
		end else if (tick) begin
			state_word_ff[STATE_FWD_SOFT_LIMIT_BIT] <= soft_active &&
				($signed(measured_position_i) >
				$signed(soft_limit_ff));
			state_word_ff[STATE_FWD_HW_LIMIT_BIT] <= hw_limit;
		end
	end

	// Forward move profile; the speed steps once per servo update.
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			move_ff <= MV_IDLE;
			jog_move_ff <= 1'b0;
			speed_ff <= 16'h0000;
		end else if (tick && hw_limit) begin
			move_ff <= MV_IDLE;
			jog_move_ff <= 1'b0;
			speed_ff <= 16'h0000;
		end else if (wr_take && avs_address_i == REG_MOVE_CTRL &&
				move_ff != MV_IDLE && !wdata[0]) begin
			move_ff <= MV_STOP;
		end else if (wr_take && avs_address_i == REG_MOVE_CTRL &&
				move_ff == MV_IDLE && wdata[0] && !soft_reached) begin
			move_ff <= MV_RUN;
			jog_move_ff <= 1'b0;
		end else if (tick) begin
			unique case (move_ff)
				MV_IDLE: begin
					if (jog_active && !soft_reached) begin
						move_ff <= MV_RUN;
						jog_move_ff <= 1'b1;
					end
				end
				MV_RUN: begin
					if (soft_reached || (jog_move_ff && !jog_active)) begin
						move_ff <= MV_STOP;
					end else if (speed_ff + ramp_step_ff >= target_speed_ff ||
							speed_ff + ramp_step_ff < speed_ff) begin
						speed_ff <= target_speed_ff;
					end else begin
						speed_ff <= speed_ff + ramp_step_ff;
					end
				end
				MV_STOP: begin
					if (speed_ff <= ramp_step_ff) begin
						speed_ff <= 16'h0000;
						move_ff <= MV_IDLE;
						jog_move_ff <= 1'b0;
					end else begin
						speed_ff <= speed_ff - ramp_step_ff;
					end
				end
			endcase
		end
	end

	assign speed_o = speed_ff;

	// Position switch.
	assign psw_axis_ok = (axis_type_ff == AXIS_TYPE_CODE_PSW_A) ||
		(axis_type_ff == AXIS_TYPE_CODE_PSW_B) || (axis_type_ff == AXIS_TYPE_CODE_PSW_C);
	assign table_wr = wr_take && (avs_address_i == REG_TABLE_DATA);
	assign fifo_clear = wr_take && avs_address_i == REG_PSW_CMD &&
		psw_axis_ok && cmd.mode == PSW_CLEAR;
	assign fifo_push = (load_ff == PS_LOAD);
	assign psw_match = psw_dir_ff ?
		($signed(measured_position_i) >= $signed(fifo_head)) :
		($signed(measured_position_i) <= $signed(fifo_head));
	assign fifo_pop = tick && psw_enabled_ff && !fifo_empty &&
		psw_match;

	compare_table u_table (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.wr_en_i(table_wr),
		.wr_idx_i(table_addr_ff),
		.wr_data_i(wdata),
		.rd_idx_i(fifo_push ? load_idx_ff : table_addr_ff),
		.rd_data_o(table_rd_data)
	);

	position_fifo u_fifo (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.clear_i(fifo_clear),
		.push_i(fifo_push),
		.push_data_i(table_rd_data),
		.pop_i(fifo_pop),
		.head_o(fifo_head),
		.empty_o(fifo_empty),
		.full_o(fifo_full),
		.count_o(fifo_count)
	);

	// Loading copies one table entry per cycle; the switch only arms once
	// the whole range is queued so no compare sees a partial list.
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			load_ff <= PS_IDLE;
			load_idx_ff <= '0;
			load_end_ff <= '0;
			psw_enabled_ff <= 1'b0;
			psw_dir_ff <= 1'b0;
			psw_opstate_ff <= 1'b0;
			psw_first_done_ff <= 1'b0;
		end else begin
			unique case (load_ff)
				PS_IDLE: begin
					// A match in the same cycle as a command still counts, except that an enable command clears psw_first_done_ff.
					if (fifo_pop) begin
						psw_first_done_ff <= 1'b1;
					end
					if (wr_take && avs_address_i == REG_PSW_CMD &&
							psw_axis_ok) begin
						if (cmd.mode == PSW_ENABLE &&
								cmd.table_start <= cmd.table_end) begin
							load_ff <= PS_LOAD;
							load_idx_ff <= cmd.table_start;
							load_end_ff <= cmd.table_end;
							psw_enabled_ff <= 1'b0;
							psw_dir_ff <= cmd.direction;
							psw_opstate_ff <= cmd.opstate;
							psw_first_done_ff <= 1'b0;
						end else if (cmd.mode == PSW_DISABLE) begin
							psw_enabled_ff <= 1'b0;
						end
					end
				end
				PS_LOAD: begin
					if (load_idx_ff == load_end_ff) begin
						load_ff <= PS_IDLE;
						psw_enabled_ff <= 1'b1;
					end else begin
						load_idx_ff <= load_idx_ff + 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			out8_ff <= 1'b0;
		end else if (fifo_pop) begin
			if (!psw_first_done_ff) begin
				out8_ff <= psw_opstate_ff;
			end else begin
				out8_ff <= !out8_ff;
			end
		end
	end

	assign digital_output_8_o = out8_ff;
endmodule

// [verification/axis_forward_limit_checker.sv]
// Port-level assertions for the axis forward limit block.
module axis_forward_limit_checker
	import axis_limit_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = SERVO_TICK_CYCLES
) (
	input wire logic clock_i, // Clock.
	input wire logic resetn_i, // Reset, active low.
	input wire logic [5:0] avs_address_i, // Address.
	input wire logic avs_read_i, // Read.
	input wire logic avs_write_i, // Write.
	input wire logic [31:0] avs_readdata_o, // Read data.
	input wire logic avs_waitrequest_o, // Wait request.
	input wire logic [15:0] speed_o, // Speed.
	input wire logic digital_output_8_o // Switch output.
);
	logic rq;
	logic rd_ok;
	assign rq = avs_read_i | avs_write_i;
	assign rd_ok = avs_read_i & !avs_waitrequest_o;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	chk_wait_first: assert property ($rose(rq) |-> avs_waitrequest_o)
		else $error("no wait cycle on a new request");
	chk_idle_nowait: assert property (!rq |-> !avs_waitrequest_o)
		else $error("wait request without a request");
	chk_unmapped_zero: assert property (rd_ok
		&& avs_address_i > REG_PSW_STATUS |-> avs_readdata_o == '0)
		else $error("unmapped read not zero");
	chk_limit_sel_range: assert property (rd_ok
		&& avs_address_i == REG_FWD_LIMIT_SEL
		|-> avs_readdata_o == 32'hFFFF_FFFF
		|| avs_readdata_o <= 32'h0000_001F)
		else $error("limit selector out of range");
	chk_jog_sel_range: assert property (rd_ok
		&& avs_address_i == REG_FORWARD_JOG_INPUT_SELECT_SEL
		|-> avs_readdata_o == 32'hFFFF_FFFF
		|| avs_readdata_o <= 32'h0000_001F)
		else $error("jog selector out of range");
	chk_state_bits: assert property (rd_ok
		&& avs_address_i == REG_STATE_WORD
		|-> (avs_readdata_o & ~32'h0000_0210) == '0)
		else $error("stray state word bit");
	chk_empty_count: assert property (rd_ok
		&& avs_address_i == REG_PSW_STATUS
		|-> avs_readdata_o[4] == (avs_readdata_o[11:6] == '0)
		&& !(avs_readdata_o[4] && avs_readdata_o[5]))
		else $error("queue empty flag disagrees with count");
	chk_speed_tick: assert property ($changed(speed_o)
		|=> $stable(speed_o) [*8])
		else $error("speed changed between servo ticks");
	chk_out_tick: assert property ($changed(digital_output_8_o)
		|=> $stable(digital_output_8_o) [*8])
		else $error("output 8 changed between servo ticks");
endmodule

bind axis_forward_limit axis_forward_limit_checker #(
	.TICK_CYCLES(TICK_CYCLES)
) chk_u (.clock_i(clock_i), .resetn_i(resetn_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .speed_o(speed_o),
	.digital_output_8_o(digital_output_8_o));

// [verification/axis_io_model.sv]
// Far-side model: limit and jog switches, and a watcher of output 8.
module axis_io_model (
	input wire logic clock_i, // Clock.
	input wire logic [15:0] unit_on_i, // Unit switches closed.
	input wire logic [15:0] drv_on_i, // Driver switches closed.
	input wire logic out8_i, // Position switch output.
	output logic [15:0] unit_n_o, // Unit input pins.
	output logic [15:0] drv_n_o, // Driver input pins.
	output int edges_o // Transitions seen on output 8.
);
	// Starts at the idle level of output 8 so reset shows no false edge.
	bit last_ff;
	// A closed switch pulls its pin to ground, so the pins idle high.
	always @(posedge clock_i) begin
		unit_n_o <= ~unit_on_i;
		drv_n_o <= ~drv_on_i;
		last_ff <= out8_i;
		if (last_ff !== out8_i)
			edges_o <= edges_o + 1;
	end
endmodule

// [verification/test_axis_forward_limit.sv]
// Self-checking bench of the axis forward limit and position switch.
module test_axis_forward_limit
	import axis_limit_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TK = 20;
	logic clock_i, resetn_i, rd, wr, wreq, out8, en, dir, ost, outm, first, ob;
	logic [5:0] addr;
	logic [7:0] at;
	logic [31:0] wd, rdata, pos, got, e;
	logic [15:0] spd, unit_n, drv_n, unit_on, drv_on;
	logic [31:0] tab[8];
	logic [31:0] sv[6];
	logic [31:0] q[$];
	logic [5:0] ra[11] = '{REG_SOFT_LIMIT, REG_REPEAT_DIST,
		REG_FWD_LIMIT_SEL, REG_FORWARD_JOG_INPUT_SELECT_SEL, REG_AXIS_TYPE, REG_STATE_WORD,
		REG_MOVE_CTRL, REG_SPEED, REG_RAMP_STEP, REG_PSW_STATUS, 6'h34};
	logic [31:0] re[11] = '{SOFT_LIMIT_RESET, REPEAT_DIST_RESET,
		32'hFFFF_FFFF, 32'hFFFF_FFFF, 0, 0, 0, 0, 32'h0000_0001,
		32'h0000_0010, 0};
	int err_total, samples_checked, seed, cyc, flips, edges, i, k;
	axis_forward_limit #(.TICK_CYCLES(TK)) dut_u (.clock_i(clock_i),
		.resetn_i(resetn_i), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
		.measured_position_i(pos), .unit_inputs_n_i(unit_n),
		.driver_inputs_n_i(drv_n), .speed_o(spd),
		.digital_output_8_o(out8));
	axis_io_model io_u (.clock_i(clock_i), .unit_on_i(unit_on),
		.drv_on_i(drv_on), .out8_i(out8), .unit_n_o(unit_n),
		.drv_n_o(drv_n), .edges_o(edges));
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			complete_run();
		end
	end
	task complete_run;
		if (err_total == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, x, g);
		end
	endtask
	// Wait request and read data are taken at the rising edge that ends
	// the transfer; only the global cycle limit ends a wait.
	task hs;
		@(posedge clock_i);
		while (wreq !== 1'b0) begin
			@(posedge clock_i);
		end
		got = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task bw(input logic [5:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		hs();
	endtask
	task rc(input string nm, input logic [5:0] a, input logic [31:0] x);
		@(posedge clock_i);
		addr <= a;
		rd <= 1'b1;
		hs();
		cmp(nm, x, got);
	endtask
	task tk(input int n);
		repeat (n * TK) @(posedge clock_i);
	endtask
	function automatic logic [31:0] sel_exp(logic [31:0] o, logic [31:0] d);
		return (d == 32'hFFFF_FFFF || d < 32'h0000_0020) ? d : o;
	endfunction
	function automatic logic [31:0] stat();
		return {20'h0_0000, 6'(q.size()), q.size() == 32, q.size() == 0,
			first, outm, dir, en};
	endfunction
	task pc(input logic [1:0] m, input logic d, input logic o,
		input int s, input int t);
		psw_cmd_t c;
		c = '0;
		c.mode = psw_mode_t'(m);
		c.direction = d;
		c.opstate = o;
		c.table_start = TABLE_AW'(s);
		c.table_end = TABLE_AW'(t);
		bw(REG_PSW_CMD, c);
		if (at inside {8'h2B, 8'h2C, 8'h2D}) begin
			if (m == 2'd0) en = 1'b0;
			if (m == 2'd2) q.delete();
			if (m == 2'd1 && s <= t) begin
				for (int j = s; j <= t; j++)
					if (q.size() < 32) q.push_back(tab[j]);
				en = 1'b1;
				dir = d;
				ost = o;
				first = 1'b0;
			end
		end
	endtask
	task step(input logic [31:0] p);
		pos <= p;
		tk(2);
		if (en && q.size() > 0 && (dir ? $signed(p) >= $signed(q[0])
			: $signed(p) <= $signed(q[0]))) begin
			ob = outm;
			outm = first ? ~outm : ost;
			if (outm !== ob) flips++;
			first = 1'b1;
			q.pop_front();
		end
		cmp("out8", 32'(outm), 32'(out8));
		rc("status", REG_PSW_STATUS, stat());
	endtask
	initial begin
		{rd, wr, addr, wd, pos, unit_on, drv_on, at} = '0;
		{en, dir, ost, outm, first} = '0;
		{err_total, samples_checked, flips} = '0;
		seed = 14;
		resetn_i = 1'b0;
		repeat (2) @(posedge clock_i);
		resetn_i <= 1'b1;
		for (i = 0; i < 11; i++) rc("reset", ra[i], re[i]);
		bw(6'h38, $random(seed));
		rc("unmapped", 6'h38, 32'h0);
		sv = '{32'h0000_0020, 32'hFFFF_FFFE, 32'h0000_001F, 32'h0,
			32'h0, 32'hFFFF_FFFF};
		sv[4] = $random(seed) & 32'h0000_001F;
		for (i = 0; i < 2; i++) begin
			e = 32'hFFFF_FFFF;
			for (k = 0; k < 6; k++) begin
				bw(i ? REG_FORWARD_JOG_INPUT_SELECT_SEL : REG_FWD_LIMIT_SEL, sv[k]);
				e = sel_exp(e, sv[k]);
				rc("select", i ? REG_FORWARD_JOG_INPUT_SELECT_SEL : REG_FWD_LIMIT_SEL, e);
			end
		end
		bw(REG_RAMP_STEP, 32'h0000_0004);
		bw(REG_SPEED, 32'h0000_0010);
		bw(REG_MOVE_CTRL, 32'h0000_0001);
		unit_on <= 16'h0020;
		tk(6);
		cmp("speed", 32'h10, 32'(spd));
		bw(REG_FWD_LIMIT_SEL, 32'h0000_0005);
		tk(2);
		cmp("speed", 32'h0, 32'(spd));
		rc("state", REG_STATE_WORD, 32'h0000_0010);
		unit_on <= 16'h0008;
		bw(REG_FWD_LIMIT_SEL, 32'h0000_0013);
		bw(REG_MOVE_CTRL, 32'h0000_0001);
		tk(6);
		cmp("speed", 32'h10, 32'(spd));
		drv_on <= 16'h0008;
		tk(2);
		cmp("speed", 32'h0, 32'(spd));
		drv_on <= 16'h0;
		unit_on <= 16'h0004;
		bw(REG_FWD_LIMIT_SEL, 32'hFFFF_FFFF);
		bw(REG_FORWARD_JOG_INPUT_SELECT_SEL, 32'h0000_0002);
		tk(6);
		cmp("speed", 32'h10, 32'(spd));
		rc("move", REG_MOVE_CTRL, 32'h0000_0003);
		unit_on <= 16'h0;
		tk(6);
		cmp("speed", 32'h0, 32'(spd));
		bw(REG_REPEAT_DIST, 32'h7FFF_FFFF);
		bw(REG_SOFT_LIMIT, 32'h0000_03E8);
		bw(REG_MOVE_CTRL, 32'h0000_0001);
		tk(6);
		pos <= 32'h0000_07D0;
		tk(7);
		cmp("speed", 32'h0, 32'(spd));
		rc("move", REG_MOVE_CTRL, 32'h0);
		rc("state", REG_STATE_WORD, 32'h0000_0200);
		bw(REG_REPEAT_DIST, 32'h0000_1388);
		bw(REG_SOFT_LIMIT, 32'h0000_1770);
		pos <= 32'h0000_1B58;
		tk(2);
		rc("state", REG_STATE_WORD, 32'h0);
		pos <= 32'h0;
		for (i = 0; i < 8; i++) begin
			tab[i] = 32'(i < 4 ? 100 * (i + 1) : 100 * (8 - i));
			bw(REG_TABLE_ADDR, 32'(i));
			bw(REG_TABLE_DATA, tab[i]);
			rc("table", REG_TABLE_DATA, tab[i]);
		end
		pc(2'd1, 1'b1, 1'b1, 0, 3);
		rc("status", REG_PSW_STATUS, stat());
		for (i = 0; i < 3; i++) begin
			at = 8'(43 + i);
			bw(REG_AXIS_TYPE, 32'(at));
			pc(2'd2, 1'b0, 1'b0, 0, 0);
			pc(2'd1, 1'b1, 1'b1, 0, 3);
			rc("status", REG_PSW_STATUS, stat());
		end
		pc(2'd3, 1'b0, 1'b0, 0, 3);
		pc(2'd1, 1'b0, 1'b0, 3, 0);
		rc("status", REG_PSW_STATUS, stat());
		step(32'd150 + ($random(seed) & 31));
		step(32'd250 + ($random(seed) & 31));
		pc(2'd0, 1'b0, 1'b0, 0, 0);
		step(32'd350 + ($random(seed) & 31));
		pc(2'd1, 1'b1, 1'b1, 0, 3);
		step(32'd350 + ($random(seed) & 31));
		pc(2'd2, 1'b0, 1'b0, 0, 0);
		pc(2'd1, 1'b0, 1'b0, 4, 7);
		step(32'd350 + ($random(seed) & 31));
		step(32'd250 + ($random(seed) & 31));
		cmp("flips", 32'(flips), 32'(edges));
		complete_run();
	end
endmodule
